// ### rtl/fms_pkg.sv
// Package for the fractional multiply-subtract-accumulate unit.
// Holds register offsets, field positions, reset values and opcodes.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package fms_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_INSN = 8'h04;
    localparam logic [7:0] OFF_SRC1 = 8'h08;
    localparam logic [7:0] OFF_SRC2 = 8'h0c;
    localparam logic [7:0] OFF_RES_LO = 8'h10;
    localparam logic [7:0] OFF_RES_HI = 8'h14;
    localparam logic [7:0] OFF_FLAGS = 8'h18;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h1c;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
    localparam logic [7:0] OFF_STATUS = 8'h24;
    // Accumulator n: high half at base + 8n, low half at base + 8n + 4
    localparam logic [7:0] OFF_ACC_BASE = 8'h40;

    // Control register fields and reset value
    localparam int CTRL_EN_BIT = 0;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;

    // Overflow flag positions in the flags register
    localparam int FLAG_WORD_BIT = 21;
    localparam int FLAG_ACC_BASE = 16;

    // Interrupt status bit positions
    localparam int IRQ_DONE = 0;
    localparam int IRQ_SAT = 1;
    localparam int IRQ_RESV = 2;
    localparam int IRQ_DIS = 3;
    localparam int IRQ_W = 4;

    // Instruction fields
    localparam logic [5:0] MAJOR_OPC = 6'h1f;
    localparam logic [4:0] SUB_WORD = 5'h16;
    localparam logic [4:0] SUB_INT_HALF = 5'h02;
    localparam logic [4:0] SUB_FRAC_HALF = 5'h06;
    localparam logic [5:0] FN_HALF_MUL = 6'h18;
    localparam logic [5:0] FN_DOT_PROD = 6'h30;
    localparam logic [2:0] ZERO_FIELD = 3'h0;

    // Saturation operands and value
    localparam logic [31:0] MIN_Q31 = 32'h8000_0000;
    localparam logic [15:0] MIN_Q15 = 16'h8000;
    localparam logic [31:0] MAX_Q31 = 32'h7fff_ffff;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Decoded operation
    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_WORD = 2'b01,
        OP_INT_HALF = 2'b10,
        OP_FRAC_HALF = 2'b11
    } fms_op_t;

endpackage : fms_pkg

// ### rtl/fms_top.sv
// Fractional multiply-subtract-accumulate unit with AXI4-Lite registers.
// Assumes i_clk at 20 MHz; the bus master follows AXI4-Lite handshakes.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Decode word fractional multiply opcode fields
// - Word product shifted, upper half sign-extended
// - Both minus one gives largest Q31
// - Word saturation sets overflow bit 21
// - Other accumulators untouched by word multiply
// - Only reserved or disabled exceptions raised
// - Decode integer halfword multiply-subtract-accumulate
// - Integer products subtracted, added to accumulator
// - Selector picks one of four accumulators
// - Integer accumulate leaves overflow flags alone
// - Decode fractional halfword multiply-subtract-accumulate
// - Q15 products shifted into Q31
// - Both 0x8000 saturate product to Q31 max
// - Lower product negated, sum accumulated
// - Halfword saturation sets flag per accumulator
module fms_top #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // AXI4-Lite write address and data
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // AXI4-Lite write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // AXI4-Lite read address and data
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [ADDR_W-1:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // Interrupt
    output logic o_irq
);

    // Elaboration check on address width
    if (ADDR_W < 8)
    begin : g_bad_addr
        $error("fms_top: ADDR_W must be at least 8");
    end

    // Byte-lane merge of write data
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] data, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                r[8*i +: 8] = data[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    // Q15 product shifted to Q31 with saturation flag on top
    function automatic logic [32:0] frac_mul(input logic [15:0] a,
        input logic [15:0] b);
        logic signed [31:0] p;
        p = $signed(a) * $signed(b);
        if (a == fms_pkg::MIN_Q15 && b == fms_pkg::MIN_Q15)
        begin
            return {1'b1, fms_pkg::MAX_Q31};
        end
        return {1'b0, p[30:0], 1'b0};
    endfunction : frac_mul

    // Instruction decode
    function automatic fms_pkg::fms_op_t decode(input logic [31:0] w);
        decode = fms_pkg::OP_NONE;
        if (w[31:26] == fms_pkg::MAJOR_OPC)
        begin
            if (w[10:6] == fms_pkg::SUB_WORD
                && w[5:0] == fms_pkg::FN_HALF_MUL)
            begin
                decode = fms_pkg::OP_WORD;
            end
            else if (w[15:13] == fms_pkg::ZERO_FIELD
                && w[5:0] == fms_pkg::FN_DOT_PROD)
            begin
                if (w[10:6] == fms_pkg::SUB_INT_HALF)
                begin
                    decode = fms_pkg::OP_INT_HALF;
                end
                else if (w[10:6] == fms_pkg::SUB_FRAC_HALF)
                begin
                    decode = fms_pkg::OP_FRAC_HALF;
                end
            end
        end
    endfunction : decode

    // Register state
    logic [31:0] ctrl_q, insn_q, src1_q, src2_q, res_lo_q, res_hi_q;
    localparam int IRQ_W_L = fms_pkg::IRQ_W;
    logic [31:0] flags_q, flag_set;
    logic [IRQ_W_L-1:0] irq_stat_q, irq_mask_q;
    logic [31:0] acc_hi_q [4];
    logic [31:0] acc_lo_q [4];
    logic [1:0] last_exc_q;
    logic exec_q;

    // Bus state
    logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic wr_fire, wr_ok, ar_fire, rd_ok;
    logic [31:0] rd_data;

    // Execution datapath signals
    fms_pkg::fms_op_t op;
    logic [1:0] sel;
    logic ext_en, exc_resv, exc_dis, do_op;
    logic signed [63:0] wprod;
    logic word_sat;
    logic [31:0] word_res;
    logic signed [31:0] ip_hi, ip_lo;
    logic signed [32:0] idiff;
    logic [32:0] fp_hi, fp_lo;
    logic [63:0] fdiff, acc_prev, acc_new;
    logic half_sat;

    // Handshake outputs
    assign o_awready = !aw_hold_q;
    assign o_wready = !w_hold_q;
    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;
    assign o_arready = !rvalid_q;
    assign o_rvalid = rvalid_q;
    assign o_rdata = rdata_q;
    assign o_rresp = rresp_q;
    assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
    assign ar_fire = i_arvalid && !rvalid_q;
    assign wr_ok = (awaddr_q[7:0] <= fms_pkg::OFF_STATUS
        || awaddr_q[7:5] == 3'h2)
        && awaddr_q[1:0] == 2'h0
        && awaddr_q[7:0] != fms_pkg::OFF_RES_LO
        && awaddr_q[7:0] != fms_pkg::OFF_RES_HI
        && awaddr_q[7:0] != fms_pkg::OFF_STATUS;

    // Write address and data capture, taken in either order
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end
        else
        begin
            if (i_awvalid && !aw_hold_q)
            begin
                aw_hold_q <= 1'b1;
                awaddr_q <= i_awaddr;
            end
            else if (wr_fire)
            begin
                aw_hold_q <= 1'b0;
            end
            if (i_wvalid && !w_hold_q)
            begin
                w_hold_q <= 1'b1;
                wdata_q <= i_wdata;
                wstrb_q <= i_wstrb;
            end
            else if (wr_fire)
            begin
                w_hold_q <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= fms_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? fms_pkg::RESP_OKAY : fms_pkg::RESP_SLVERR;
        end
        else if (i_bready)
        begin
            bvalid_q <= 1'b0;
        end
    end

    // Read decode
    always_comb
    begin
        rd_data = 32'h0;
        rd_ok = (i_araddr[1:0] == 2'h0);
        case (i_araddr[7:0])
            fms_pkg::OFF_CTRL: rd_data = ctrl_q;
            fms_pkg::OFF_INSN: rd_data = insn_q;
            fms_pkg::OFF_SRC1: rd_data = src1_q;
            fms_pkg::OFF_SRC2: rd_data = src2_q;
            fms_pkg::OFF_RES_LO: rd_data = res_lo_q;
            fms_pkg::OFF_RES_HI: rd_data = res_hi_q;
            fms_pkg::OFF_FLAGS: rd_data = flags_q;
            fms_pkg::OFF_IRQ_STAT: rd_data = {28'h0, irq_stat_q};
            fms_pkg::OFF_IRQ_MASK: rd_data = {28'h0, irq_mask_q};
            fms_pkg::OFF_STATUS: rd_data = {29'h0, exec_q, last_exc_q};
            default:
            begin
                if (i_araddr[7:5] == 3'h2 && i_araddr[1:0] == 2'h0)
                begin
                    rd_data = i_araddr[2] ? acc_lo_q[i_araddr[4:3]]
                        : acc_hi_q[i_araddr[4:3]];
                end
                else
                begin
                    rd_ok = 1'b0;
                end
            end
        endcase
    end

    // Read response
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= fms_pkg::RESP_OKAY;
        end
        else if (ar_fire)
        begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_ok ? rd_data : 32'h0;
            rresp_q <= rd_ok ? fms_pkg::RESP_OKAY : fms_pkg::RESP_SLVERR;
        end
        else if (i_rready)
        begin
            rvalid_q <= 1'b0;
        end
    end

    // Decode and exception checks
    assign op = decode(insn_q);
    assign sel = insn_q[12:11];
    assign ext_en = ctrl_q[fms_pkg::CTRL_EN_BIT];
    assign exc_resv = exec_q && op == fms_pkg::OP_NONE;
    assign exc_dis = exec_q && op != fms_pkg::OP_NONE && !ext_en;
    assign do_op = exec_q && op != fms_pkg::OP_NONE && ext_en;

    // Word fractional multiply
    assign wprod = $signed(src1_q) * $signed(src2_q);
    assign word_sat = src1_q == fms_pkg::MIN_Q31
        && src2_q == fms_pkg::MIN_Q31;
    assign word_res = word_sat ? fms_pkg::MAX_Q31
        : wprod[62:31];

    // Halfword products and differences
    assign ip_hi = $signed(src1_q[31:16]) * $signed(src2_q[31:16]);
    assign ip_lo = $signed(src1_q[15:0]) * $signed(src2_q[15:0]);
    assign idiff = {ip_hi[31], ip_hi} - {ip_lo[31], ip_lo};
    assign fp_hi = frac_mul(src1_q[31:16], src2_q[31:16]);
    assign fp_lo = frac_mul(src1_q[15:0], src2_q[15:0]);
    assign half_sat = fp_hi[32] || fp_lo[32];
    assign fdiff = {{32{fp_hi[31]}}, fp_hi[31:0]}
        - {{32{fp_lo[31]}}, fp_lo[31:0]};
    assign acc_prev = {acc_hi_q[sel], acc_lo_q[sel]};
    assign acc_new = (op == fms_pkg::OP_INT_HALF)
        ? acc_prev + {{31{idiff[32]}}, idiff}
        : acc_prev + fdiff;

    // Control, instruction and operand registers
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            ctrl_q <= fms_pkg::CTRL_RST;
            insn_q <= 32'h0;
            src1_q <= 32'h0;
            src2_q <= 32'h0;
            irq_mask_q <= '0;
        end
        else if (wr_fire && wr_ok)
        begin
            case (awaddr_q[7:0])
                fms_pkg::OFF_CTRL: ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
                fms_pkg::OFF_INSN: insn_q <= merge(insn_q, wdata_q, wstrb_q);
                fms_pkg::OFF_SRC1: src1_q <= merge(src1_q, wdata_q, wstrb_q);
                fms_pkg::OFF_SRC2: src2_q <= merge(src2_q, wdata_q, wstrb_q);
                fms_pkg::OFF_IRQ_MASK:
                begin
                    if (wstrb_q[0])
                    begin
                        irq_mask_q <= wdata_q[IRQ_W_L-1:0];
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    // Start pulse, one cycle after an instruction write
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            exec_q <= 1'b0;
        end
        else
        begin
            exec_q <= wr_fire && wr_ok
                && awaddr_q[7:0] == fms_pkg::OFF_INSN;
        end
    end

    // Destination result and last exception code
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            res_lo_q <= 32'h0;
            res_hi_q <= 32'h0;
            last_exc_q <= 2'h0;
        end
        else if (exec_q)
        begin
            last_exc_q <= {exc_dis, exc_resv};
            if (do_op && op == fms_pkg::OP_WORD)
            begin
                res_lo_q <= word_res;
                res_hi_q <= {32{word_res[31]}};
            end
        end
    end

    // Accumulators; word multiply leaves all four as they were
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            for (int i = 0; i < 4; i++)
            begin
                acc_hi_q[i] <= 32'h0;
                acc_lo_q[i] <= 32'h0;
            end
        end
        else if (do_op && op != fms_pkg::OP_WORD)
        begin
            acc_hi_q[sel] <= acc_new[63:32];
            acc_lo_q[sel] <= acc_new[31:0];
        end
        else if (wr_fire && wr_ok && awaddr_q[7:5] == 3'h2)
        begin
            if (awaddr_q[2])
            begin
                acc_lo_q[awaddr_q[4:3]] <= merge(acc_lo_q[awaddr_q[4:3]],
                    wdata_q, wstrb_q);
            end
            else
            begin
                acc_hi_q[awaddr_q[4:3]] <= merge(acc_hi_q[awaddr_q[4:3]],
                    wdata_q, wstrb_q);
            end
        end
    end

    // Overflow flags; hardware set wins over a software write
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            flags_q <= 32'h0;
        end
        else
        begin
            flags_q <= ((wr_fire && wr_ok
                && awaddr_q[7:0] == fms_pkg::OFF_FLAGS)
                ? merge(flags_q, wdata_q, wstrb_q) : flags_q)
                | flag_set;
        end
    end

    // Flag bits set by this operation; integer form sets none
    always_comb
    begin
        flag_set = 32'h0;
        if (do_op && op == fms_pkg::OP_WORD && word_sat)
        begin
            flag_set[fms_pkg::FLAG_WORD_BIT] = 1'b1;
        end
        if (do_op && op == fms_pkg::OP_FRAC_HALF && half_sat)
        begin
            flag_set[fms_pkg::FLAG_ACC_BASE + 32'(sel)] = 1'b1;
        end
    end

    // Interrupt status, write one to clear, set wins
    logic [IRQ_W_L-1:0] irq_set, irq_clr;
    always_comb
    begin
        irq_set = '0;
        irq_set[fms_pkg::IRQ_DONE] = do_op;
        irq_set[fms_pkg::IRQ_SAT] = flag_set != 32'h0;
        irq_set[fms_pkg::IRQ_RESV] = exc_resv;
        irq_set[fms_pkg::IRQ_DIS] = exc_dis;
        irq_clr = '0;
        if (wr_fire && wr_ok && awaddr_q[7:0] == fms_pkg::OFF_IRQ_STAT
            && wstrb_q[0])
        begin
            irq_clr = wdata_q[IRQ_W_L-1:0];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            irq_stat_q <= '0;
        end
        else
        begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
        end
    end

    // Level interrupt output
    assign o_irq = |(irq_stat_q & irq_mask_q);

endmodule : fms_top

`default_nettype wire

// ### bench/fms_core_model.sv
// Core-side AXI4-Lite master model.
// Assumes a slave port; the bench calls wr and rd by hierarchy.
`timescale 1ns/1ps
`default_nettype none
module fms_core_model (
    // Clock
    input wire logic i_clk,
    // Write channels
    output logic o_awvalid,
    input wire logic i_awready,
    output logic [7:0] o_awaddr,
    output logic o_wvalid,
    input wire logic i_wready,
    output logic [31:0] o_wdata,
    output logic [3:0] o_wstrb,
    input wire logic i_bvalid,
    output logic o_bready,
    input wire logic [1:0] i_bresp,
    // Read channels
    output logic o_arvalid,
    input wire logic i_arready,
    output logic [7:0] o_araddr,
    input wire logic i_rvalid,
    output logic o_rready,
    input wire logic [31:0] i_rdata,
    input wire logic [1:0] i_rresp
);
    logic slow;

    // Idle bus at time zero
    initial
    begin
        slow = 1'b0;
        {o_awvalid, o_wvalid, o_arvalid, o_bready, o_rready} = 5'h0;
        {o_awaddr, o_araddr, o_wdata} = 48'h0;
        o_wstrb = 4'hf;
    end

    // One write; slow mode raises bready only after bvalid shows
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        output logic [1:0] r);
        @(posedge i_clk);
        o_awvalid <= 1'b1;
        o_awaddr <= a;
        o_wvalid <= 1'b1;
        o_wdata <= d;
        o_bready <= !slow;
        forever
        begin
            @(posedge i_clk);
            if (o_awvalid && i_awready)
                o_awvalid <= 1'b0;
            if (o_wvalid && i_wready)
                o_wvalid <= 1'b0;
            if (i_bvalid && o_bready)
            begin
                r = i_bresp;
                o_bready <= 1'b0;
                break;
            end
            if (i_bvalid)
                o_bready <= 1'b1;
        end
    endtask : wr

    // One read; same slow handling on rready
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge i_clk);
        o_arvalid <= 1'b1;
        o_araddr <= a;
        o_rready <= !slow;
        forever
        begin
            @(posedge i_clk);
            if (o_arvalid && i_arready)
                o_arvalid <= 1'b0;
            if (i_rvalid && o_rready)
            begin
                d = i_rdata;
                r = i_rresp;
                o_rready <= 1'b0;
                break;
            end
            if (i_rvalid)
                o_rready <= 1'b1;
        end
    endtask : rd
endmodule : fms_core_model
`default_nettype wire

// ### bench/fms_checker.sv
// Bus handshake assertions for the multiply unit.
// Assumes one clock and an active-low reset.
`timescale 1ns/1ps
`default_nettype none
module fms_checker (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Bus signals
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic [1:0] o_bresp,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0] o_rresp,
    input wire logic o_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    // Address and data taken at one edge
    sequence s_write_taken;
        i_awvalid && o_awready && i_wvalid && o_wready;
    endsequence
    // Read address taken
    sequence s_read_taken;
        i_arvalid && o_arready;
    endsequence

    a_write_answer: assert property (s_write_taken |-> ##[1:4] o_bvalid)
        else $error("no bvalid");
    a_read_answer: assert property (s_read_taken |=> o_rvalid)
        else $error("rvalid late");
    a_rdata_hold: assert property (o_rvalid && !i_rready |=>
        o_rvalid && $stable(o_rdata) && $stable(o_rresp))
        else $error("rdata moved");
    a_bresp_hold: assert property (o_bvalid && !i_bready |=>
        o_bvalid && $stable(o_bresp))
        else $error("bresp moved");
    a_read_blocked: assert property (o_rvalid |-> !o_arready)
        else $error("arready busy");
    a_read_done: assert property (o_rvalid && i_rready |=> !o_rvalid)
        else $error("rvalid stuck");
    a_write_done: assert property (o_bvalid && i_bready |=> !o_bvalid)
        else $error("bvalid stuck");
    a_err_zero: assert property (o_rvalid && o_rresp == 2'h2 |->
        o_rdata == 32'h0)
        else $error("error rdata");
    a_resp_legal: assert property (o_rvalid |-> o_rresp inside {2'h0, 2'h2})
        else $error("bad rresp");
    a_irq_reset: assert property ($rose(i_rst_b) |-> !o_irq)
        else $error("irq at reset");
endmodule : fms_checker
`default_nettype wire

bind fms_top fms_checker i_chk (.i_clk(i_clk),
    .i_rst_b(i_rst_b), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid),
    .i_bready(i_bready), .o_bresp(o_bresp), .i_arvalid(i_arvalid),
    .o_arready(o_arready), .o_rvalid(o_rvalid),
    .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .o_irq(o_irq));

// ### bench/testbench.sv
// Self-checking bench for the multiply unit.
// Assumes the core model drives the bus; one 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic i_clk;
    logic i_rst_b;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, flg;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    int n_fail, tests_run;
    int cycles = 0;

    // Clock at 50 ns
    initial
    begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    // Core model and unit under test
    fms_core_model i_core (.i_clk(i_clk), .o_awvalid(awvalid),
        .i_awready(awready), .o_awaddr(awaddr), .o_wvalid(wvalid),
        .i_wready(wready), .o_wdata(wdata), .o_wstrb(wstrb),
        .i_bvalid(bvalid), .o_bready(bready), .i_bresp(bresp),
        .o_arvalid(arvalid), .i_arready(arready), .o_araddr(araddr),
        .i_rvalid(rvalid), .o_rready(rready), .i_rdata(rdata),
        .i_rresp(rresp));
    fms_top i_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_awvalid(awvalid),
        .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid),
        .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
        .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
        .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
        .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata),
        .o_rresp(rresp), .o_irq(irq));

    // Verdict and end of run
    task automatic complete_run();
        $display("compares %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    // Hang guard
    always @(posedge i_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_fail++;
            complete_run();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
            n_fail++;
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_core.wr(a, d, r);
        chk("bresp", {30'h0, r}, 32'h0);
    endtask : wr

    task automatic rd(input string what, input logic [7:0] a,
        input logic [31:0] exp);
        logic [31:0] d;
        i_core.rd(a, d, r);
        chk(what, d, exp);
    endtask : rd

    // Instruction word with zero register fields
    function automatic logic [31:0] ins(input logic [4:0] sub,
        input logic [5:0] fn, input logic [1:0] sel);
        return {6'h1f, 10'h0, 3'h0, sel, sub, fn};
    endfunction : ins

    task automatic run(input logic [31:0] insn, input logic [31:0] s1,
        input logic [31:0] s2);
        wr(fms_pkg::OFF_SRC1, s1);
        wr(fms_pkg::OFF_SRC2, s2);
        wr(fms_pkg::OFF_INSN, insn);
    endtask : run

    task automatic acc_set(input int n, input logic [31:0] hi,
        input logic [31:0] lo);
        wr(fms_pkg::OFF_ACC_BASE + 8'(8 * n), hi);
        wr(fms_pkg::OFF_ACC_BASE + 8'(8 * n + 4), lo);
    endtask : acc_set

    task automatic acc_chk(input int n, input logic [31:0] hi,
        input logic [31:0] lo);
        rd("acc_hi", fms_pkg::OFF_ACC_BASE + 8'(8 * n), hi);
        rd("acc_lo", fms_pkg::OFF_ACC_BASE + 8'(8 * n + 4), lo);
    endtask : acc_chk

    task automatic res_chk(input logic [31:0] lo, input logic [31:0] hi);
        rd("res_lo", fms_pkg::OFF_RES_LO, lo);
        rd("res_hi", fms_pkg::OFF_RES_HI, hi);
    endtask : res_chk

    // Main sequence
    initial
    begin
        n_fail = 0;
        tests_run = 0;
        i_rst_b = 1'b0;
        repeat (8) @(posedge i_clk);
        i_rst_b <= 1'b1;
        rd("ctrl", fms_pkg::OFF_CTRL, 32'h1);
        rd("flags", fms_pkg::OFF_FLAGS, 32'h0);
        i_core.rd(8'h3c, flg, r);
        chk("unmapped", {30'h0, r}, 32'h2);
        i_core.slow = 1'b1;
        i_core.wr(fms_pkg::OFF_RES_LO, 32'h5, r);
        chk("ro write", {30'h0, r}, 32'h2);
        rd("res_lo", fms_pkg::OFF_RES_LO, 32'h0);
        i_core.slow = 1'b0;
        $display("test registers done");
        run(ins(5'h16, 6'h18, 2'd0), 32'h4000_0000, 32'h4000_0000);
        res_chk(32'h2000_0000, 32'h0);
        run(ins(5'h16, 6'h18, 2'd0), 32'h4000_0000, 32'hc000_0000);
        res_chk(32'he000_0000, 32'hffff_ffff);
        rd("flags", fms_pkg::OFF_FLAGS, 32'h0);
        for (int n = 1; n < 4; n++)
            acc_set(n, n, 32'ha0 + n);
        run(ins(5'h16, 6'h18, 2'd0), 32'h8000_0000, 32'h8000_0000);
        res_chk(32'h7fff_ffff, 32'h0);
        rd("flags", fms_pkg::OFF_FLAGS, 32'h0020_0000);
        for (int n = 1; n < 4; n++)
            acc_chk(n, n, 32'ha0 + n);
        $display("test word multiply done");
        for (int n = 0; n < 4; n++)
        begin
            acc_set(n, 32'h0, 32'hffff_ffff);
            run(ins(5'h02, 6'h30, 2'(n)), 32'h0003_0002, 32'h0004_0005);
            acc_chk(n, 32'h1, 32'h1);
        end
        acc_set(2, 32'h0, 32'h0);
        run(ins(5'h02, 6'h30, 2'd2), 32'h0001_0002, 32'h0001_0003);
        acc_chk(2, 32'hffff_ffff, 32'hffff_fffb);
        rd("flags", fms_pkg::OFF_FLAGS, 32'h0020_0000);
        $display("test integer accumulate done");
        flg = 32'h0020_0000;
        for (int n = 0; n < 4; n++)
        begin
            acc_set(n, 32'h0, 32'h0);
            run(ins(5'h06, 6'h30, 2'(n)), 32'h8000_4000, 32'h8000_4000);
            acc_chk(n, 32'h0, 32'h5fff_ffff);
            flg[16 + n] = 1'b1;
            rd("flags", fms_pkg::OFF_FLAGS, flg);
        end
        acc_set(0, 32'h0, 32'h0);
        run(ins(5'h06, 6'h30, 2'd0), 32'h2000_4000, 32'h4000_4000);
        acc_chk(0, 32'hffff_ffff, 32'hf000_0000);
        rd("flags", fms_pkg::OFF_FLAGS, flg);
        $display("test fractional accumulate done");
        wr(fms_pkg::OFF_IRQ_MASK, 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            wr(fms_pkg::OFF_IRQ_STAT, 32'hf);
            run(i == 0 ? ins(5'h02, 6'h18, 2'd0) : i == 1 ?
                ins(5'h02, 6'h30, 2'd0) | 32'h2000 :
                ins(5'h16, 6'h18, 2'd0) ^ 32'h0400_0000, 32'h1, 32'h1);
            rd("irq_stat", fms_pkg::OFF_IRQ_STAT, 32'h4);
            rd("status", fms_pkg::OFF_STATUS, 32'h1);
        end
        res_chk(32'h7fff_ffff, 32'h0);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(fms_pkg::OFF_IRQ_MASK, 32'h4);
        chk("irq on", {31'h0, irq}, 32'h1);
        wr(fms_pkg::OFF_IRQ_STAT, 32'h4);
        rd("irq_stat", fms_pkg::OFF_IRQ_STAT, 32'h0);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        $display("test reserved and interrupt done");
        wr(fms_pkg::OFF_CTRL, 32'h0);
        wr(fms_pkg::OFF_IRQ_MASK, 32'h8);
        run(ins(5'h16, 6'h18, 2'd0), 32'h4000_0000, 32'h4000_0000);
        rd("irq_stat", fms_pkg::OFF_IRQ_STAT, 32'h8);
        rd("status", fms_pkg::OFF_STATUS, 32'h2);
        res_chk(32'h7fff_ffff, 32'h0);
        chk("irq disabled", {31'h0, irq}, 32'h1);
        wr(fms_pkg::OFF_CTRL, 32'h1);
        run(ins(5'h16, 6'h18, 2'd0), 32'h4000_0000, 32'h4000_0000);
        rd("irq_stat", fms_pkg::OFF_IRQ_STAT, 32'h9);
        res_chk(32'h2000_0000, 32'h0);
        $display("test disabled extension done");
        complete_run();
    end
endmodule : testbench
`default_nettype wire
